// *** dmt_defines.svh ***
// offsets, selector codes, reset values and field positions of the dual timer
`ifndef DMT_DEFINES_SVH
`define DMT_DEFINES_SVH

// mode selector reset value and port-move codes
`define DMT_MODE_RESET 5'h1f
`define DMT_MODE_CLEAR 5'h10
`define DMT_MODE_WR_BIT 4

// register index inside a timer, low three bits of the selector
`define DMT_IDX_CAP_L 3'h0
`define DMT_IDX_CAP_H 3'h1
`define DMT_IDX_CMP2_L 3'h2
`define DMT_IDX_CMP2_H 3'h3
`define DMT_IDX_CMP1_L 3'h4
`define DMT_IDX_CMP1_H 3'h5
`define DMT_IDX_CTL_B 3'h6
`define DMT_IDX_CTL_A 3'h7

// reset values
`define DMT_CNT_RESET 16'h0000
`define DMT_CMP_RESET 16'h0000
`define DMT_CTL_A_RESET 8'h00
`define DMT_CTL_B_RESET 8'h00
`define DMT_CNT_ONES 16'hffff

// control A bit positions
`define DMT_CTLA_OVIE 0
`define DMT_CTLA_OVF 1
`define DMT_CTLA_CMIE 2
`define DMT_CTLA_CMF1 3
`define DMT_CTLA_CMF2 4
`define DMT_CTLA_CPIE 5
`define DMT_CTLA_CPF1 6
`define DMT_CTLA_CPF2 7

// control B bit positions
`define DMT_CTLB_MODE_LSB 0
`define DMT_CTLB_PS_LSB 2
`define DMT_CTLB_EV_EDGE 5
`define DMT_CTLB_CAP_EDGE 6

`endif

// *** dmt_pkg.sv ***
// types shared by the dual multi-function timer
package dmt_pkg;

  // timer operating mode
  typedef enum logic [1:0] {
    DMT_SW_TIMER = 2'b00,
    DMT_PWM = 2'b01,
    DMT_CAP_CMP = 2'b10,
    DMT_EXT_EVENT = 2'b11
  } dmt_mode_type;

  // which compare register is the current target
  typedef enum logic {
    DMT_PH_CMP1 = 1'b0,
    DMT_PH_CMP2 = 1'b1
  } dmt_phase_type;

  // control A: enables and pending flags
  typedef struct packed {
    logic cpf2;
    logic cpf1;
    logic cpie;
    logic cmf2;
    logic cmf1;
    logic cmie;
    logic ovf;
    logic ovie;
  } dmt_ctl_a_type;

  // control B: mode, prescale, edges, unrelated spare bit
  typedef struct packed {
    logic rtcc_ov;
    logic capture_edge_select;
    logic event_clock_edge_select;
    logic [2:0] prescale_select;
    dmt_mode_type timer_mode_select;
  } dmt_ctl_b_type;

  // software-visible registers of one timer
  typedef struct packed {
    logic [15:0] cap;
    logic [15:0] second_compare_value;
    logic [15:0] first_compare_value;
    dmt_ctl_b_type ctl_b;
    dmt_ctl_a_type ctl_a;
  } dmt_regs_type;

  // command from the port-move decoder to one timer
  typedef struct packed {
    logic wr;
    logic clear;
    logic [2:0] idx;
    logic [7:0] data;
  } dmt_cmd_type;

  // pin inputs of one timer
  typedef struct packed {
    logic capture_one;
    logic capture_two;
    logic event_pin;
    logic dir_out;
  } dmt_pins_type;

  // whole state of one timer
  typedef struct packed {
    dmt_regs_type regs;
    logic [15:0] cnt;
    logic [6:0] pre;
    dmt_phase_type phase;
    logic out;
    logic pin_oe;
    logic irq;
    logic ev_prev;
    logic c1_prev;
    logic c2_prev;
  } dmt_tmr_state_type;

  // whole state of the top
  typedef struct packed {
    logic [4:0] mode;
    logic [7:0] rd_data;
    logic rd_valid;
  } dmt_top_state_type;

endpackage : dmt_pkg

// *** dmt_top.sv ***
// dual multi-function timer with mode-selector register access
//
// Contract
// - two timers: counter, capture, two compares
// - reset zeroes counter, then counts per tick
// - tick from event pin or prescaled clock
// - mode selector: literal 4 bits, move 5
// - port moves read/write selected timer register
// - code 10h clears counter, targets first compare
// - interrupts on overflow, match, capture when enabled
// - pwm: alternate targets, restart at zero
// - first compare low time, second high
// - target below count: wrap, output holds
// - pwm drives pin only when direction out
// - software timer: like pwm, pin untouched
// - separate flags for each match and overflow
// - event mode counts selected event pin edges
// - capture/compare: no restart, match toggles output
// - capture/compare prescaler divides 1 to 128
// - capture one to capture, two to compare two
// - capture flags; shared edge select for both
// - prescale code n divides by two to n
// - two-bit mode field selects four modes
// - edge select one rising, zero falling
`timescale 1ns/1ps
`include "dmt_defines.svh"

// one timer channel
module dmt_timer #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire dmt_pkg::dmt_cmd_type cmd,
  input wire dmt_pkg::dmt_pins_type pins,
  output dmt_pkg::dmt_regs_type regs,
  output logic pin_out,
  output logic pin_oe,
  output logic irq
);

  // byte-wide register access needs exactly two bytes
  if (CNT_W != 16) begin : g_bad_width
    $error("dmt_timer: CNT_W must be 16");
  end

  dmt_pkg::dmt_tmr_state_type s_ff; // registered state
  dmt_pkg::dmt_tmr_state_type nxt_s; // next state
  dmt_pkg::dmt_mode_type mode; // current mode
  logic [6:0] pre_mask; // prescaler terminal mask
  logic ev_edge; // selected event pin edge
  logic c1_edge; // selected capture one edge
  logic c2_edge; // selected capture two edge
  logic tick; // counter advances this cycle
  logic [15:0] target; // active compare value
  logic hit; // counter equals active target
  logic at_ones; // counter at all ones

  assign mode = s_ff.regs.ctl_b.timer_mode_select;

  // prescale mask, three-bit code gives divide 1..128
  assign pre_mask = 7'((8'h01 << s_ff.regs.ctl_b.prescale_select) - 8'h01);

  // edge detectors, one selects rising and zero falling
  assign ev_edge = s_ff.regs.ctl_b.event_clock_edge_select ?
                   (pins.event_pin & ~s_ff.ev_prev) : (~pins.event_pin & s_ff.ev_prev);
  assign c1_edge = s_ff.regs.ctl_b.capture_edge_select ?
                   (pins.capture_one & ~s_ff.c1_prev) : (~pins.capture_one & s_ff.c1_prev);
  assign c2_edge = s_ff.regs.ctl_b.capture_edge_select ?
                   (pins.capture_two & ~s_ff.c2_prev) : (~pins.capture_two & s_ff.c2_prev);

  // tick source: event edge in event mode, prescaler otherwise
  assign tick = (mode == dmt_pkg::DMT_EXT_EVENT) ? ev_edge :
                ((s_ff.pre & pre_mask) == pre_mask);

  // compare target and match
  assign target = (s_ff.phase == dmt_pkg::DMT_PH_CMP2) ?
                  s_ff.regs.second_compare_value : s_ff.regs.first_compare_value;
  assign hit = (s_ff.cnt == target);
  assign at_ones = (s_ff.cnt == `DMT_CNT_ONES);

  // next-state logic of the channel
  always_comb begin
    logic set_ovf;
    logic set_cmf1;
    logic set_cmf2;
    logic set_cpf1;
    logic set_cpf2;
    set_ovf = 1'b0;
    set_cmf1 = 1'b0;
    set_cmf2 = 1'b0;
    set_cpf1 = 1'b0;
    set_cpf2 = 1'b0;
    nxt_s = s_ff;
    nxt_s.ev_prev = pins.event_pin;
    nxt_s.c1_prev = pins.capture_one;
    nxt_s.c2_prev = pins.capture_two;
    nxt_s.pre = s_ff.pre + 7'h01;
    // counter behaviour per mode
    if (tick) begin
      if (mode == dmt_pkg::DMT_CAP_CMP) begin
        // free running, match toggles the output
        nxt_s.cnt = s_ff.cnt + 16'h0001;
        set_ovf = at_ones;
        if (s_ff.cnt == s_ff.regs.first_compare_value) begin
          nxt_s.out = ~s_ff.out;
          set_cmf1 = 1'b1;
        end
      end else if (hit) begin
        // match: restart and swap target
        nxt_s.cnt = `DMT_CNT_RESET;
        if (s_ff.phase == dmt_pkg::DMT_PH_CMP1) begin
          nxt_s.phase = dmt_pkg::DMT_PH_CMP2;
          set_cmf1 = 1'b1;
        end else begin
          nxt_s.phase = dmt_pkg::DMT_PH_CMP1;
          set_cmf2 = 1'b1;
        end
      end else begin
        // count on, wrapping past all ones if target is behind
        nxt_s.cnt = s_ff.cnt + 16'h0001;
        set_ovf = at_ones;
      end
    end
    // captures only in capture/compare mode
    if (mode == dmt_pkg::DMT_CAP_CMP) begin
      set_cpf1 = c1_edge;
      set_cpf2 = c2_edge;
    end
    // software write of a register
    if (cmd.wr) begin
      case (cmd.idx)
        `DMT_IDX_CMP2_L: nxt_s.regs.second_compare_value[7:0] = cmd.data;
        `DMT_IDX_CMP2_H: nxt_s.regs.second_compare_value[15:8] = cmd.data;
        `DMT_IDX_CMP1_L: nxt_s.regs.first_compare_value[7:0] = cmd.data;
        `DMT_IDX_CMP1_H: nxt_s.regs.first_compare_value[15:8] = cmd.data;
        `DMT_IDX_CTL_B: nxt_s.regs.ctl_b = dmt_pkg::dmt_ctl_b_type'(cmd.data);
        `DMT_IDX_CTL_A: nxt_s.regs.ctl_a = dmt_pkg::dmt_ctl_a_type'(cmd.data);
        default: nxt_s.regs = nxt_s.regs; // capture bytes are read only
      endcase
    end
    // capture loads win over a write in the same cycle
    if (set_cpf1) begin
      nxt_s.regs.cap = s_ff.cnt;
    end
    if (set_cpf2) begin
      nxt_s.regs.second_compare_value = s_ff.cnt;
    end
    // clear command overrides the tick
    if (cmd.clear) begin
      nxt_s.cnt = `DMT_CNT_RESET;
      nxt_s.phase = dmt_pkg::DMT_PH_CMP1;
      nxt_s.out = 1'b0;
    end
    // alternating modes: low awaiting first, high awaiting second
    if (mode != dmt_pkg::DMT_CAP_CMP) begin
      nxt_s.out = (nxt_s.phase == dmt_pkg::DMT_PH_CMP2);
    end
    // hardware flag sets win over a software clear
    nxt_s.regs.ctl_a.ovf = nxt_s.regs.ctl_a.ovf | set_ovf;
    nxt_s.regs.ctl_a.cmf1 = nxt_s.regs.ctl_a.cmf1 | set_cmf1;
    nxt_s.regs.ctl_a.cmf2 = nxt_s.regs.ctl_a.cmf2 | set_cmf2;
    nxt_s.regs.ctl_a.cpf1 = nxt_s.regs.ctl_a.cpf1 | set_cpf1;
    nxt_s.regs.ctl_a.cpf2 = nxt_s.regs.ctl_a.cpf2 | set_cpf2;
    // interrupt request from enabled pending flags
    nxt_s.irq = (nxt_s.regs.ctl_a.ovf & nxt_s.regs.ctl_a.ovie) |
                ((nxt_s.regs.ctl_a.cmf1 | nxt_s.regs.ctl_a.cmf2) & nxt_s.regs.ctl_a.cmie) |
                ((nxt_s.regs.ctl_a.cpf1 | nxt_s.regs.ctl_a.cpf2) & nxt_s.regs.ctl_a.cpie);
    // pin taken over in pwm and capture/compare, only if direction is out
    nxt_s.pin_oe = pins.dir_out &
                   ((nxt_s.regs.ctl_b.timer_mode_select == dmt_pkg::DMT_PWM) |
                    (nxt_s.regs.ctl_b.timer_mode_select == dmt_pkg::DMT_CAP_CMP));
  end

  // state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.cnt <= `DMT_CNT_RESET;
      s_ff.regs.first_compare_value <= `DMT_CMP_RESET;
      s_ff.regs.second_compare_value <= `DMT_CMP_RESET;
      s_ff.regs.ctl_a <= dmt_pkg::dmt_ctl_a_type'(`DMT_CTL_A_RESET);
      s_ff.regs.ctl_b <= dmt_pkg::dmt_ctl_b_type'(`DMT_CTL_B_RESET);
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign regs = s_ff.regs;
  assign pin_out = s_ff.out;
  assign pin_oe = s_ff.pin_oe;
  assign irq = s_ff.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // alternating-mode match on first target
  sequence s_match_first;
    tick && hit && !cmd.clear && (mode != dmt_pkg::DMT_CAP_CMP) &&
    (s_ff.phase == dmt_pkg::DMT_PH_CMP1);
  endsequence

  // restart at zero, now on second target with pin level high
  sequence s_restart_second;
    (s_ff.cnt == 16'h0000) && (s_ff.phase == dmt_pkg::DMT_PH_CMP2) && s_ff.out &&
    s_ff.regs.ctl_a.cmf1;
  endsequence

  property p_reset_zero;
    $past(reset) |-> (s_ff.cnt == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("counter not zero after reset");

  property p_pwm_restart;
    s_match_first |=> s_restart_second;
  endproperty
  a_pwm_restart: assert property (p_pwm_restart) else $error("no restart on first match");

  property p_clear;
    cmd.clear |=> (s_ff.cnt == 16'h0000) && (s_ff.phase == dmt_pkg::DMT_PH_CMP1);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset counter");

  property p_cc_step;
    (tick && !cmd.clear && mode == dmt_pkg::DMT_CAP_CMP) |=>
      (s_ff.cnt == $past(s_ff.cnt) + 16'h0001);
  endproperty
  a_cc_step: assert property (p_cc_step) else $error("capture/compare counter skipped");

  property p_cc_toggle;
    (tick && !cmd.clear && mode == dmt_pkg::DMT_CAP_CMP &&
     s_ff.cnt == s_ff.regs.first_compare_value) |=> (s_ff.out != $past(s_ff.out));
  endproperty
  a_cc_toggle: assert property (p_cc_toggle) else $error("match did not toggle output");

  property p_capture_one;
    (mode == dmt_pkg::DMT_CAP_CMP && c1_edge) |=>
      (s_ff.regs.cap == $past(s_ff.cnt)) && s_ff.regs.ctl_a.cpf1;
  endproperty
  a_capture_one: assert property (p_capture_one) else $error("capture one lost");

  property p_overflow;
    (tick && at_ones && !(mode != dmt_pkg::DMT_CAP_CMP && hit)) |=> s_ff.regs.ctl_a.ovf;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not set");

  property p_irq;
    (s_ff.regs.ctl_a.ovf && s_ff.regs.ctl_a.ovie) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled overflow without request");

  property p_div_two;
    (mode != dmt_pkg::DMT_EXT_EVENT && s_ff.regs.ctl_b.prescale_select == 3'h1 && tick &&
     !cmd.wr) |=> !tick ##1 tick;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two wrong");

  property p_sw_pin_free;
    (mode == dmt_pkg::DMT_SW_TIMER && !cmd.wr) |=> !pin_oe;
  endproperty
  a_sw_pin_free: assert property (p_sw_pin_free) else $error("software timer drove pin");

  property p_pwm_level;
    (mode != dmt_pkg::DMT_CAP_CMP) |-> (pin_out == (s_ff.phase == dmt_pkg::DMT_PH_CMP2));
  endproperty
  a_pwm_level: assert property (p_pwm_level) else $error("pwm level not from phase");

endmodule : dmt_timer

// top: mode selector, port-move decoder and two timers
module dmt_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic mode_lit_wr,
  input wire logic mode_w_wr,
  input wire logic port_b_control_move,
  input wire logic port_c_control_move,
  input wire logic [7:0] w_data,
  input wire dmt_pkg::dmt_pins_type timer_one_pins,
  input wire dmt_pkg::dmt_pins_type timer_two_pins,
  output logic [7:0] mode_value,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic timer_one_output_pin,
  output logic timer_one_output_pin_oe,
  output logic timer_one_irq,
  output logic timer_two_output_pin,
  output logic timer_two_output_pin_oe,
  output logic timer_two_irq
);

  dmt_pkg::dmt_top_state_type s_ff; // registered state
  dmt_pkg::dmt_top_state_type nxt_s; // next state
  dmt_pkg::dmt_cmd_type cmd_one; // command to timer one
  dmt_pkg::dmt_cmd_type cmd_two; // command to timer two
  dmt_pkg::dmt_regs_type regs_one; // timer one registers
  dmt_pkg::dmt_regs_type regs_two; // timer two registers
  logic sel_write; // selector codes 12h..17h
  logic sel_read; // selector codes 00h..07h
  logic sel_clear; // selector code 10h

  // selected byte of a timer register set
  function automatic logic [7:0] dmt_rd_byte(input dmt_pkg::dmt_regs_type r,
                                             input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      `DMT_IDX_CAP_L: b = r.cap[7:0];
      `DMT_IDX_CAP_H: b = r.cap[15:8];
      `DMT_IDX_CMP2_L: b = r.second_compare_value[7:0];
      `DMT_IDX_CMP2_H: b = r.second_compare_value[15:8];
      `DMT_IDX_CMP1_L: b = r.first_compare_value[7:0];
      `DMT_IDX_CMP1_H: b = r.first_compare_value[15:8];
      `DMT_IDX_CTL_B: b = r.ctl_b;
      `DMT_IDX_CTL_A: b = r.ctl_a;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : dmt_rd_byte

  // selector decode
  assign sel_read = (s_ff.mode[4:3] == 2'b00);
  assign sel_write = s_ff.mode[`DMT_MODE_WR_BIT] & ~s_ff.mode[3] & (s_ff.mode[2:1] != 2'b00);
  assign sel_clear = (s_ff.mode == `DMT_MODE_CLEAR);

  // commands to the channels
  always_comb begin
    cmd_one.wr = port_b_control_move & sel_write;
    cmd_one.clear = port_b_control_move & sel_clear;
    cmd_one.idx = s_ff.mode[2:0];
    cmd_one.data = w_data;
    cmd_two.wr = port_c_control_move & sel_write;
    cmd_two.clear = port_c_control_move & sel_clear;
    cmd_two.idx = s_ff.mode[2:0];
    cmd_two.data = w_data;
  end

  // mode selector and read path
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rd_valid = 1'b0;
    if (mode_w_wr) begin
      nxt_s.mode = w_data[4:0];
    end else if (mode_lit_wr) begin
      nxt_s.mode = {s_ff.mode[4], w_data[3:0]};
    end
    if (port_b_control_move && sel_read) begin
      nxt_s.rd_data = dmt_rd_byte(regs_one, s_ff.mode[2:0]);
      nxt_s.rd_valid = 1'b1;
    end else if (port_c_control_move && sel_read) begin
      nxt_s.rd_data = dmt_rd_byte(regs_two, s_ff.mode[2:0]);
      nxt_s.rd_valid = 1'b1;
    end
  end

  // top state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_ff.mode <= `DMT_MODE_RESET;
      s_ff.rd_data <= 8'h00;
      s_ff.rd_valid <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign mode_value = {3'h0, s_ff.mode};
  assign rd_data = s_ff.rd_data;
  assign rd_valid = s_ff.rd_valid;

  // two independent channels
  dmt_timer #(.CNT_W(16)) u_timer_one (
    .mclk(mclk),
    .reset(reset),
    .cmd(cmd_one),
    .pins(timer_one_pins),
    .regs(regs_one),
    .pin_out(timer_one_output_pin),
    .pin_oe(timer_one_output_pin_oe),
    .irq(timer_one_irq)
  );

  dmt_timer #(.CNT_W(16)) u_timer_two (
    .mclk(mclk),
    .reset(reset),
    .cmd(cmd_two),
    .pins(timer_two_pins),
    .regs(regs_two),
    .pin_out(timer_two_output_pin),
    .pin_oe(timer_two_output_pin_oe),
    .irq(timer_two_irq)
  );

endmodule : dmt_top

// *** dmt_pin_model.sv ***
// pin-side model of one timer: capture lines, event clock line and port direction
`timescale 1ns/1ps

module dmt_pin_model (
  input wire logic mclk,
  input wire logic dir_out,
  output dmt_pkg::dmt_pins_type pins
);
  logic cap_one; // capture input one level
  logic cap_two; // capture input two level
  logic ev; // event clock pin level

  // lines idle low
  initial begin
    cap_one = 1'b0;
    cap_two = 1'b0;
    ev = 1'b0;
  end

  // msb to lsb as the pin struct orders them
  assign pins = {cap_one, cap_two, ev, dir_out};

  // moves one capture line just after a falling clock edge
  task automatic set_line(input int which, input logic lvl);
    @(negedge mclk);
    if (which == 1) begin
      cap_one = lvl;
    end else begin
      cap_two = lvl;
    end
  endtask : set_line

  // n rising event edges, each level held at least two cycles so no edge is lost
  task automatic pulse_events(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      ev = 1'b1;
      repeat (2) @(negedge mclk);
      ev = 1'b0;
      repeat (2) @(negedge mclk);
    end
    repeat (4) @(negedge mclk);
  endtask : pulse_events

endmodule : dmt_pin_model

// *** tb_dmt_top.sv ***
// self-checking testbench of the dual multi-function timer
`timescale 1ns/1ps
`include "dmt_defines.svh"

module tb_dmt_top;
  logic mclk; // 100 MHz system clock
  logic reset; // sync reset, active high
  logic mode_lit_wr; // literal selector write
  logic mode_w_wr; // working-register selector write
  logic mv_b; // port move, timer one
  logic mv_c; // port move, timer two
  logic [7:0] w_data; // working register
  logic dir1; // timer one pin direction
  logic dir2; // timer two pin direction
  dmt_pkg::dmt_pins_type t1p; // timer one pins
  dmt_pkg::dmt_pins_type t2p; // timer two pins
  logic [7:0] mode_value;
  logic [7:0] rd_data;
  logic rd_valid;
  logic o1;
  logic oe1;
  logic irq1;
  logic o2;
  logic oe2;
  logic irq2;
  int bad_count; // mismatches
  int n_compared; // comparisons made
  logic [7:0] rb; // read byte
  logic [15:0] c_a; // first capture
  logic [15:0] c_b; // second capture
  int hi_n; // pwm high cycles
  int lo_n; // pwm low cycles
  int k; // bounded wait count

  dmt_top dut (.mclk(mclk), .reset(reset), .mode_lit_wr(mode_lit_wr), .mode_w_wr(mode_w_wr),
    .port_b_control_move(mv_b), .port_c_control_move(mv_c), .w_data(w_data),
    .timer_one_pins(t1p), .timer_two_pins(t2p), .mode_value(mode_value), .rd_data(rd_data),
    .rd_valid(rd_valid), .timer_one_output_pin(o1), .timer_one_output_pin_oe(oe1),
    .timer_one_irq(irq1), .timer_two_output_pin(o2), .timer_two_output_pin_oe(oe2),
    .timer_two_irq(irq2));
  dmt_pin_model pm1 (.mclk(mclk), .dir_out(dir1), .pins(t1p));
  dmt_pin_model pm2 (.mclk(mclk), .dir_out(dir2), .pins(t2p));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // compare of a byte or word result
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check16

  // compare of a single-bit result
  task automatic check1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check1

  // selector write, literal or from the working register
  task automatic mode_wr(input logic lit, input logic [7:0] d);
    @(negedge mclk);
    mode_lit_wr = lit;
    mode_w_wr = ~lit;
    w_data = d;
    @(negedge mclk);
    mode_lit_wr = 1'b0;
    mode_w_wr = 1'b0;
  endtask : mode_wr

  // selector load then one port move on the chosen timer
  task automatic move(input int t, input logic [4:0] sel, input logic [7:0] d);
    mode_wr(1'b0, {3'h0, sel});
    mv_b = (t == 1);
    mv_c = (t == 2);
    w_data = d;
    @(negedge mclk);
    mv_b = 1'b0;
    mv_c = 1'b0;
  endtask : move

  // register read, answer expected one cycle after the move
  task automatic rd(input int t, input logic [2:0] idx, output logic [7:0] q);
    move(t, {2'b00, idx}, 8'h00);
    check1("read answer", 1'b1, rd_valid);
    q = rd_data;
  endtask : rd

  // register write
  task automatic wr(input int t, input logic [2:0] idx, input logic [7:0] d);
    move(t, {2'b10, idx}, d);
  endtask : wr

  // counts, verdict, end of run
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // cuts a hang short
  initial begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    $display("unexpected watchdog expiry: expected end of tests, seen none");
    tally_and_finish();
  end

  // main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    reset = 1'b1;
    mode_lit_wr = 1'b0;
    mode_w_wr = 1'b0;
    mv_b = 1'b0;
    mv_c = 1'b0;
    w_data = 8'h00;
    dir1 = 1'b0;
    dir2 = 1'b0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    // reset values of both timers
    check16("mode selector", 16'h001f, {8'h00, mode_value});
    for (int i = 0; i < 7; i++) begin
      rd(1, i[2:0], rb);
      check16("timer one register", 16'h0000, {8'h00, rb});
      rd(2, i[2:0], rb);
      check16("timer two register", 16'h0000, {8'h00, rb});
    end
    // selector widths
    mode_wr(1'b0, 8'hf4);
    check16("mode selector", 16'h0014, {8'h00, mode_value});
    mode_wr(1'b1, 8'hf3);
    check16("mode selector", 16'h0013, {8'h00, mode_value});
    move(1, 5'h11, 8'h00);
    check1("reserved read answer", 1'b0, rd_valid);
    // compare writes land in timer one only
    for (int i = 2; i < 6; i++) begin
      wr(1, i[2:0], 8'h30 + i[7:0]);
      rd(1, i[2:0], rb);
      check16("compare byte", {8'h00, 8'h30 + i[7:0]}, {8'h00, rb});
      rd(2, i[2:0], rb);
      check16("other timer byte", 16'h0000, {8'h00, rb});
    end
    // prescaler codes: ticks between two captures taken 128 cycles apart
    wr(1, `DMT_IDX_CTL_B, 8'h42);
    move(1, 5'h10, 8'h00);
    wr(1, `DMT_IDX_CTL_A, 8'h20);
    for (int ps = 0; ps < 8; ps++) begin
      wr(1, `DMT_IDX_CTL_B, {2'b01, 1'b0, ps[2:0], 2'b10});
      pm1.set_line(1, 1'b1);
      repeat (127) @(negedge mclk);
      pm1.set_line(2, 1'b1);
      pm1.set_line(1, 1'b0);
      pm1.set_line(2, 1'b0);
      repeat (3) @(negedge mclk);
      rd(1, `DMT_IDX_CAP_L, c_a[7:0]);
      rd(1, `DMT_IDX_CAP_H, c_a[15:8]);
      rd(1, `DMT_IDX_CMP2_L, c_b[7:0]);
      rd(1, `DMT_IDX_CMP2_H, c_b[15:8]);
      check16("capture spacing", 16'(128 >> ps), c_b - c_a);
    end
    rd(1, `DMT_IDX_CTL_A, rb);
    check16("capture flags", 16'h00e0, {8'h00, rb});
    check1("capture interrupt", 1'b1, irq1);
    // pwm waveform, low 3+1 ticks, high 1+1 ticks
    wr(1, `DMT_IDX_CMP1_L, 8'h03);
    wr(1, `DMT_IDX_CMP1_H, 8'h00);
    wr(1, `DMT_IDX_CMP2_L, 8'h01);
    wr(1, `DMT_IDX_CMP2_H, 8'h00);
    dir1 = 1'b1;
    wr(1, `DMT_IDX_CTL_B, 8'h01);
    move(1, 5'h10, 8'h00);
    k = 0;
    while (o1 !== 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    hi_n = 0;
    while (o1 === 1'b1 && hi_n < 50) begin
      @(negedge mclk);
      hi_n++;
    end
    lo_n = 0;
    while (o1 === 1'b0 && lo_n < 50) begin
      @(negedge mclk);
      lo_n++;
    end
    check16("pwm high time", 16'h0002, 16'(hi_n));
    check16("pwm low time", 16'h0004, 16'(lo_n));
    check1("pwm pin enable", 1'b1, oe1);
    dir1 = 1'b0;
    repeat (2) @(negedge mclk);
    check1("pin enable, input direction", 1'b0, oe1);
    dir1 = 1'b1;
    wr(1, `DMT_IDX_CTL_B, 8'h00);
    repeat (2) @(negedge mclk);
    check1("software timer pin enable", 1'b0, oe1);
    // event mode on timer two, rising edges
    wr(2, `DMT_IDX_CTL_B, 8'h23);
    wr(2, `DMT_IDX_CMP1_L, 8'h04);
    move(2, 5'h10, 8'h00);
    wr(2, `DMT_IDX_CTL_A, 8'h00);
    pm2.pulse_events(4);
    rd(2, `DMT_IDX_CTL_A, rb);
    check16("event flags after four", 16'h0000, {8'h00, rb});
    pm2.pulse_events(1);
    rd(2, `DMT_IDX_CTL_A, rb);
    check16("event flags after five", 16'h0008, {8'h00, rb});
    check1("event output awaiting second", 1'b1, o2);
    check1("timer two interrupt, disabled", 1'b0, irq2);
    check1("timer two pin enable, input direction", 1'b0, oe2);
    // capture/compare on timer two: match toggles, falling capture edge
    wr(2, `DMT_IDX_CMP1_L, 8'h08);
    wr(2, `DMT_IDX_CTL_B, 8'h02);
    move(2, 5'h10, 8'h00);
    repeat (20) @(negedge mclk);
    check1("compare toggle output", 1'b1, o2);
    wr(2, `DMT_IDX_CTL_A, 8'h00);
    pm2.set_line(1, 1'b1);
    repeat (2) @(negedge mclk);
    rd(2, `DMT_IDX_CTL_A, rb);
    check16("flags after rising capture edge", 16'h0000, {8'h00, rb});
    pm2.set_line(1, 1'b0);
    repeat (2) @(negedge mclk);
    rd(2, `DMT_IDX_CTL_A, rb);
    check16("flags after falling capture edge", 16'h0040, {8'h00, rb});
    rd(2, `DMT_IDX_CAP_L, rb);
    check16("capture past compare match", 16'h001e, {8'h00, rb});
    // first compare rewritten below the count: wrap through all ones
    wr(1, `DMT_IDX_CTL_B, 8'h01);
    wr(1, `DMT_IDX_CMP2_H, 8'hff);
    wr(1, `DMT_IDX_CMP1_H, 8'h02);
    wr(1, `DMT_IDX_CMP1_L, 8'h00);
    move(1, 5'h10, 8'h00);
    wr(1, `DMT_IDX_CTL_A, 8'h00);
    repeat (400) @(negedge mclk);
    wr(1, `DMT_IDX_CMP1_H, 8'h00);
    repeat (1000) @(negedge mclk);
    check1("output awaiting first compare", 1'b0, o1);
    rd(1, `DMT_IDX_CTL_A, rb);
    check16("flags before wrap", 16'h0000, {8'h00, rb});
    repeat (65000) @(negedge mclk);
    rd(1, `DMT_IDX_CTL_A, rb);
    check16("flags after wrap", 16'h000a, {8'h00, rb});
    check1("output awaiting second compare", 1'b1, o1);
    tally_and_finish();
  end

endmodule : tb_dmt_top
